// file: shared/flash_host_pkg.sv
// Constants, command codes, status layout and register map for the
// flash command host.
// Assumes a 10 MHz system clock; all pin timing is derived from it.
package flash_host_pkg;

   // System clock
   localparam int CLK_PERIOD_NS = 100;

   // Pin timing in nanoseconds; least times, rounded up to cycles
   localparam int T_SETUP_NS = 100;
   localparam int T_WE_PULSE_NS = 100;
   localparam int T_HOLD_NS = 100;
   localparam int T_ACCESS_NS = 200;
   localparam int T_GAP_NS = 100;
   localparam int SYNC_CYC = 2;

   localparam int SETUP_RAW = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WE_RAW = (T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_RAW = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACC_RAW = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GAP_RAW = (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int SETUP_CYC = (SETUP_RAW < 1) ? 1 : SETUP_RAW;
   localparam int WE_CYC = (WE_RAW < 1) ? 1 : WE_RAW;
   localparam int HOLD_CYC = (HOLD_RAW < 1) ? 1 : HOLD_RAW;
   localparam int ACC_CYC = (ACC_RAW < 1) ? 1 : ACC_RAW;
   localparam int GAP_CYC = (GAP_RAW < 1) ? 1 : GAP_RAW;

   // Phase timer loads
   localparam int TMR_W = 4;
   localparam logic [TMR_W-1:0] TMR_ZERO = 4'h0;
   localparam logic [TMR_W-1:0] TMR_ONE = 4'h1;
   localparam logic [TMR_W-1:0] SETUP_LOAD = TMR_W'(SETUP_CYC - 1);
   localparam logic [TMR_W-1:0] WE_LOAD = TMR_W'(WE_CYC - 1);
   localparam logic [TMR_W-1:0] HOLD_LOAD = TMR_W'(HOLD_CYC - 1);
   localparam logic [TMR_W-1:0] READ_LOAD = TMR_W'(ACC_CYC + SYNC_CYC - 1);
   localparam logic [TMR_W-1:0] GAP_LOAD = TMR_W'(GAP_CYC - 1);

   // Flash command codes
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h40;
   localparam logic [7:0] CMD_PROGRAM_ALT = 8'h10;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
   localparam logic [7:0] CMD_ERASE_SUSPEND = 8'hB0;
   localparam logic [7:0] CMD_ERASE_RESUME = 8'hD0;
   localparam logic [7:0] CMD_UPPER_BYTE = 8'h00;

   // Flash status byte layout
   localparam int SR_READY_BIT = 7;
   localparam int SR_PAUSED_BIT = 6;
   localparam int SR_ERASE_FAIL_BIT = 5;
   localparam int SR_PROG_FAIL_BIT = 4;
   localparam int SR_SUPPLY_LOW_BIT = 3;
   localparam logic [7:0] SR_USED_MASK = 8'hF8;
   localparam logic [7:0] SR_RESET = 8'h00;

   // Host operations
   typedef enum logic [2:0] {
      OP_READ_ARRAY  = 3'b000,
      OP_READ_ID     = 3'b001,
      OP_READ_STATUS = 3'b010,
      OP_CLEAR       = 3'b011,
      OP_PROGRAM     = 3'b100,
      OP_ERASE       = 3'b101,
      OP_SUSPEND     = 3'b110,
      OP_RESUME      = 3'b111
   } op_type;

   // Kind of one bus step in an operation
   typedef enum logic [1:0] {
      KIND_WRITE = 2'b00,
      KIND_READ  = 2'b01,
      KIND_POLL  = 2'b10,
      KIND_END   = 2'b11
   } kind_type;

   // Host register map
   localparam int REG_ADR_W = 8;
   localparam logic [REG_ADR_W-1:0] REG_CMD = 8'h00;
   localparam logic [REG_ADR_W-1:0] REG_ADDR = 8'h04;
   localparam logic [REG_ADR_W-1:0] REG_WDATA = 8'h08;
   localparam logic [REG_ADR_W-1:0] REG_RDATA = 8'h0C;
   localparam logic [REG_ADR_W-1:0] REG_STATUS = 8'h10;

   // Field positions
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_ALT_BIT = 4;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_ERR_BIT = 2;
   localparam int STAT_BYTE_LSB = 8;
   localparam logic [31:0] REG_ZERO = 32'h0000_0000;

endpackage

// file: core/sync_stage.sv
// Two-flop synchroniser for a bus of pin inputs.
// Assumes the inputs are asynchronous to clk_sys.
`timescale 1ns/1ps
module sync_stage #(
   parameter int WIDTH = 16
) (
   input  wire logic             clk_sys,
   input  wire logic             arst_n,
   input  wire logic             clkEn,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] meta_r;

   // First stage is read only by the second
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         meta_r  <= '0;
         syncOut <= '0;
      end else if (clkEn) begin
         meta_r  <= asyncIn;
         syncOut <= meta_r;
      end
   end

endmodule // sync_stage

// file: core/flash_host.sv
// Host controller that runs flash command sequences on the parallel pins.
// Assumes a flash on the pins and software on the plain register port.
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module flash_host #(
   parameter int ADDR_W = 18,
   parameter int DATA_W = 16
) (
   input  wire logic                             clk_sys,
   input  wire logic                             arst_n,
   input  wire logic                             clkEn,
   input  wire logic [flash_host_pkg::REG_ADR_W-1:0] regAddr,
   input  wire logic [31:0]                      regWrData,
   input  wire logic                             regWrStb,
   input  wire logic                             regRdStb,
   output logic      [31:0]                      regRdData,
   output logic      [ADDR_W-1:0]                flashAddr,
   output logic      [DATA_W-1:0]                flashDqOut,
   output logic                                  flashDqOe,
   input  wire logic [DATA_W-1:0]                flashDqIn,
   output logic                                  flashCeN,
   output logic                                  flashOeN,
   output logic                                  flashWeN
);

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_NEXT   = 3'b001,
      ST_WSET   = 3'b010,
      ST_WPULSE = 3'b011,
      ST_WHOLD  = 3'b100,
      ST_RWAIT  = 3'b101,
      ST_GAP    = 3'b110
   } bus_state_type;

   bus_state_type                        state_r;
   bus_state_type                        state_nxt;
   flash_host_pkg::op_type               op_r;
   flash_host_pkg::op_type               op_nxt;
   logic                                 alt_r;
   logic                                 alt_nxt;
   logic [1:0]                           step_r;
   logic [1:0]                           step_nxt;
   logic [flash_host_pkg::TMR_W-1:0]     timer_r;
   logic [flash_host_pkg::TMR_W-1:0]     timer_nxt;
   logic [ADDR_W-1:0]                    addr_r;
   logic [ADDR_W-1:0]                    addr_nxt;
   logic [DATA_W-1:0]                    wdata_r;
   logic [DATA_W-1:0]                    wdata_nxt;
   logic [DATA_W-1:0]                    rdVal_r;
   logic [DATA_W-1:0]                    rdVal_nxt;
   logic [7:0]                           statByte_r;
   logic [7:0]                           statByte_nxt;
   logic                                 done_r;
   logic                                 done_nxt;
   logic [31:0]                          regRdData_nxt;
   logic [ADDR_W-1:0]                    flashAddr_nxt;
   logic [DATA_W-1:0]                    flashDqOut_nxt;
   logic                                 flashDqOe_nxt;
   logic                                 flashCeN_nxt;
   logic                                 flashOeN_nxt;
   logic                                 flashWeN_nxt;
   logic [DATA_W-1:0]                    dqSync;
   flash_host_pkg::kind_type             stepKind;
   logic [DATA_W-1:0]                    stepData;
   logic                                 busy;
   logic                                 opError;
   logic                                 doneSet;
   logic [7:0]                           readStat;

   sync_stage #(
      .WIDTH (DATA_W)
   ) u_dq_sync (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .clkEn   (clkEn),
      .asyncIn (flashDqIn),
      .syncOut (dqSync)
   );

   assign busy = (state_r != ST_IDLE);
   // Status bits above the reserved field only; upper data byte ignored
   assign readStat = dqSync[7:0] & flash_host_pkg::SR_USED_MASK;
   // Any error flag in the last status byte
   assign opError = statByte_r[flash_host_pkg::SR_ERASE_FAIL_BIT]
                  | statByte_r[flash_host_pkg::SR_PROG_FAIL_BIT]
                  | statByte_r[flash_host_pkg::SR_SUPPLY_LOW_BIT];

   // Bus step table per operation
   always_comb begin
      stepKind = flash_host_pkg::KIND_END;
      stepData = {flash_host_pkg::CMD_UPPER_BYTE, flash_host_pkg::CMD_READ_ARRAY};
      case (op_r)
         flash_host_pkg::OP_READ_ARRAY: begin
            stepData = {flash_host_pkg::CMD_UPPER_BYTE,
                        flash_host_pkg::CMD_READ_ARRAY};
            stepKind = (step_r == 2'b00) ? flash_host_pkg::KIND_WRITE
                     : (step_r == 2'b01) ? flash_host_pkg::KIND_READ
                     : flash_host_pkg::KIND_END;
         end
         flash_host_pkg::OP_READ_ID: begin
            stepData = {flash_host_pkg::CMD_UPPER_BYTE,
                        flash_host_pkg::CMD_READ_ID};
            stepKind = (step_r == 2'b00) ? flash_host_pkg::KIND_WRITE
                     : (step_r == 2'b01) ? flash_host_pkg::KIND_READ
                     : flash_host_pkg::KIND_END;
         end
         flash_host_pkg::OP_READ_STATUS: begin
            stepData = {flash_host_pkg::CMD_UPPER_BYTE,
                        flash_host_pkg::CMD_READ_STATUS};
            stepKind = (step_r == 2'b00) ? flash_host_pkg::KIND_WRITE
                     : (step_r == 2'b01) ? flash_host_pkg::KIND_READ
                     : flash_host_pkg::KIND_END;
         end
         flash_host_pkg::OP_CLEAR: begin
            stepData = {flash_host_pkg::CMD_UPPER_BYTE,
                        flash_host_pkg::CMD_CLEAR_STATUS};
            stepKind = (step_r == 2'b00) ? flash_host_pkg::KIND_WRITE
                     : flash_host_pkg::KIND_END;
         end
         flash_host_pkg::OP_PROGRAM: begin
            if (step_r == 2'b00) begin
               stepKind = flash_host_pkg::KIND_WRITE;
               stepData = {flash_host_pkg::CMD_UPPER_BYTE,
                           alt_r ? flash_host_pkg::CMD_PROGRAM_ALT
                                 : flash_host_pkg::CMD_PROGRAM_SETUP};
            end else if (step_r == 2'b01) begin
               stepKind = flash_host_pkg::KIND_WRITE;
               stepData = wdata_r;
            end else if (step_r == 2'b10) begin
               stepKind = flash_host_pkg::KIND_POLL;
            end else begin
               stepKind = flash_host_pkg::KIND_END;
            end
         end
         flash_host_pkg::OP_ERASE: begin
            if (step_r == 2'b00) begin
               stepKind = flash_host_pkg::KIND_WRITE;
               stepData = {flash_host_pkg::CMD_UPPER_BYTE,
                           flash_host_pkg::CMD_ERASE_SETUP};
            end else if (step_r == 2'b01) begin
               stepKind = flash_host_pkg::KIND_WRITE;
               stepData = {flash_host_pkg::CMD_UPPER_BYTE,
                           flash_host_pkg::CMD_ERASE_CONFIRM};
            end else if (step_r == 2'b10) begin
               stepKind = flash_host_pkg::KIND_POLL;
            end else begin
               stepKind = flash_host_pkg::KIND_END;
            end
         end
         flash_host_pkg::OP_SUSPEND: begin
            stepData = {flash_host_pkg::CMD_UPPER_BYTE,
                        flash_host_pkg::CMD_ERASE_SUSPEND};
            stepKind = (step_r == 2'b00) ? flash_host_pkg::KIND_WRITE
                     : (step_r == 2'b01) ? flash_host_pkg::KIND_POLL
                     : flash_host_pkg::KIND_END;
         end
         flash_host_pkg::OP_RESUME: begin
            stepData = {flash_host_pkg::CMD_UPPER_BYTE,
                        flash_host_pkg::CMD_ERASE_RESUME};
            stepKind = (step_r == 2'b00) ? flash_host_pkg::KIND_WRITE
                     : flash_host_pkg::KIND_END;
         end
         default: begin
            stepKind = flash_host_pkg::KIND_END;
         end
      endcase
   end

   // Register port and bus sequencer
   always_comb begin
      state_nxt      = state_r;
      op_nxt         = op_r;
      alt_nxt        = alt_r;
      step_nxt       = step_r;
      timer_nxt      = timer_r;
      addr_nxt       = addr_r;
      wdata_nxt      = wdata_r;
      rdVal_nxt      = rdVal_r;
      statByte_nxt   = statByte_r;
      done_nxt       = done_r;
      doneSet        = 1'b0;
      regRdData_nxt  = flash_host_pkg::REG_ZERO;
      flashAddr_nxt  = flashAddr;
      flashDqOut_nxt = flashDqOut;
      flashDqOe_nxt  = flashDqOe;
      flashCeN_nxt   = flashCeN;
      flashOeN_nxt   = flashOeN;
      flashWeN_nxt   = flashWeN;

      if (regRdStb) begin
         case (regAddr)
            flash_host_pkg::REG_ADDR:  regRdData_nxt = 32'(addr_r);
            flash_host_pkg::REG_WDATA: regRdData_nxt = 32'(wdata_r);
            flash_host_pkg::REG_RDATA: regRdData_nxt = 32'(rdVal_r);
            flash_host_pkg::REG_STATUS: begin
               regRdData_nxt[flash_host_pkg::STAT_BUSY_BIT] = busy;
               regRdData_nxt[flash_host_pkg::STAT_DONE_BIT] = done_r;
               regRdData_nxt[flash_host_pkg::STAT_ERR_BIT]  = opError;
               regRdData_nxt[flash_host_pkg::STAT_BYTE_LSB +: 8] = statByte_r;
            end
            default: regRdData_nxt = flash_host_pkg::REG_ZERO;
         endcase
      end

      // Address and data writes are refused while busy
      if (regWrStb && !busy) begin
         case (regAddr)
            flash_host_pkg::REG_ADDR:  addr_nxt = regWrData[ADDR_W-1:0];
            flash_host_pkg::REG_WDATA: wdata_nxt = regWrData[DATA_W-1:0];
            flash_host_pkg::REG_CMD: begin
               op_nxt = flash_host_pkg::op_type'(
                  regWrData[flash_host_pkg::CMD_OP_LSB +: 3]);
               alt_nxt   = regWrData[flash_host_pkg::CMD_ALT_BIT];
               step_nxt  = 2'b00;
               done_nxt  = 1'b0;
               state_nxt = ST_NEXT;
            end
            default: ;
         endcase
      end
      if (regWrStb && regAddr == flash_host_pkg::REG_STATUS
          && regWrData[flash_host_pkg::STAT_DONE_BIT]) begin
         done_nxt = 1'b0;
      end

      case (state_r)
         ST_IDLE: ;
         ST_NEXT: begin
            flashAddr_nxt = addr_r;
            if (stepKind == flash_host_pkg::KIND_WRITE) begin
               flashDqOut_nxt = stepData;
               flashDqOe_nxt  = 1'b1;
               flashCeN_nxt   = 1'b0;
               timer_nxt      = flash_host_pkg::SETUP_LOAD;
               state_nxt      = ST_WSET;
            end else if (stepKind == flash_host_pkg::KIND_END) begin
               doneSet   = 1'b1;
               state_nxt = ST_IDLE;
            end else begin
               flashCeN_nxt = 1'b0;
               flashOeN_nxt = 1'b0;
               timer_nxt    = flash_host_pkg::READ_LOAD;
               state_nxt    = ST_RWAIT;
            end
         end
         ST_WSET: begin
            if (timer_r == flash_host_pkg::TMR_ZERO) begin
               flashWeN_nxt = 1'b0;
               timer_nxt    = flash_host_pkg::WE_LOAD;
               state_nxt    = ST_WPULSE;
            end else begin
               timer_nxt = timer_r - flash_host_pkg::TMR_ONE;
            end
         end
         ST_WPULSE: begin
            if (timer_r == flash_host_pkg::TMR_ZERO) begin
               flashWeN_nxt = 1'b1;
               timer_nxt    = flash_host_pkg::HOLD_LOAD;
               state_nxt    = ST_WHOLD;
            end else begin
               timer_nxt = timer_r - flash_host_pkg::TMR_ONE;
            end
         end
         ST_WHOLD: begin
            if (timer_r == flash_host_pkg::TMR_ZERO) begin
               flashCeN_nxt  = 1'b1;
               flashDqOe_nxt = 1'b0;
               step_nxt      = step_r + 2'b01;
               timer_nxt     = flash_host_pkg::GAP_LOAD;
               state_nxt     = ST_GAP;
            end else begin
               timer_nxt = timer_r - flash_host_pkg::TMR_ONE;
            end
         end
         ST_RWAIT: begin
            if (timer_r == flash_host_pkg::TMR_ZERO) begin
               // Strobes rise so the next poll gets a fresh edge
               flashCeN_nxt = 1'b1;
               flashOeN_nxt = 1'b1;
               rdVal_nxt    = dqSync;
               if (stepKind == flash_host_pkg::KIND_POLL
                   || op_r == flash_host_pkg::OP_READ_STATUS) begin
                  statByte_nxt = readStat;
               end
               // Poll again while the flash reports busy
               if (stepKind == flash_host_pkg::KIND_POLL
                   && !dqSync[flash_host_pkg::SR_READY_BIT]) begin
                  step_nxt = step_r;
               end else begin
                  step_nxt = step_r + 2'b01;
               end
               timer_nxt = flash_host_pkg::GAP_LOAD;
               state_nxt = ST_GAP;
            end else begin
               timer_nxt = timer_r - flash_host_pkg::TMR_ONE;
            end
         end
         ST_GAP: begin
            if (timer_r == flash_host_pkg::TMR_ZERO) begin
               state_nxt = ST_NEXT;
            end else begin
               timer_nxt = timer_r - flash_host_pkg::TMR_ONE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase

      // Completion wins over a software clear in the same cycle
      if (doneSet) begin
         done_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_r    <= ST_IDLE;
         op_r       <= flash_host_pkg::OP_READ_ARRAY;
         alt_r      <= 1'b0;
         step_r     <= 2'b00;
         timer_r    <= flash_host_pkg::TMR_ZERO;
         addr_r     <= '0;
         wdata_r    <= '0;
         rdVal_r    <= '0;
         statByte_r <= flash_host_pkg::SR_RESET;
         done_r     <= 1'b0;
         regRdData  <= flash_host_pkg::REG_ZERO;
         flashAddr  <= '0;
         flashDqOut <= '0;
         flashDqOe  <= 1'b0;
         flashCeN   <= 1'b1;
         flashOeN   <= 1'b1;
         flashWeN   <= 1'b1;
      end else if (clkEn) begin
         state_r    <= state_nxt;
         op_r       <= op_nxt;
         alt_r      <= alt_nxt;
         step_r     <= step_nxt;
         timer_r    <= timer_nxt;
         addr_r     <= addr_nxt;
         wdata_r    <= wdata_nxt;
         rdVal_r    <= rdVal_nxt;
         statByte_r <= statByte_nxt;
         done_r     <= done_nxt;
         regRdData  <= regRdData_nxt;
         flashAddr  <= flashAddr_nxt;
         flashDqOut <= flashDqOut_nxt;
         flashDqOe  <= flashDqOe_nxt;
         flashCeN   <= flashCeN_nxt;
         flashOeN   <= flashOeN_nxt;
         flashWeN   <= flashWeN_nxt;
      end
   end

endmodule // flash_host

// file: dv/flash_host_props.sv
// Pin and register port checks for the flash host.
// Assumes it is bound into every flash_host instance.
`timescale 1ns/1ps
module flash_host_props #(
   parameter int ADDR_W = 18,
   parameter int DATA_W = 16
) (
   input wire logic              clk_sys,
   input wire logic              arst_n,
   input wire logic              regRdStb,
   input wire logic [31:0]       regRdData,
   input wire logic [ADDR_W-1:0] flashAddr,
   input wire logic [DATA_W-1:0] flashDqOut,
   input wire logic              flashDqOe,
   input wire logic              flashCeN,
   input wire logic              flashOeN,
   input wire logic              flashWeN
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   write_framed_a: assert property (!flashWeN |-> !flashCeN && flashOeN && flashDqOe)
      else $error("write strobe outside driven select");
   we_pulse_a: assert property ($fell(flashWeN) |=> flashWeN && !flashCeN ##1 flashCeN)
      else $error("write pulse length wrong");
   write_hold_a: assert property ($fell(flashWeN) |=> $stable(flashAddr) && $stable(flashDqOut))
      else $error("address or data moved in write");
   ce_setup_a: assert property ($fell(flashCeN) && flashDqOe |=> $fell(flashWeN))
      else $error("write strobe late");
   bus_release_a: assert property ($rose(flashCeN) |-> !flashDqOe && flashOeN && flashWeN)
      else $error("bus not released");
   read_len_a: assert property ($fell(flashOeN) |-> !flashOeN[*4] ##1 flashOeN)
      else $error("read strobe length wrong");
   read_fresh_a: assert property ($fell(flashOeN) |-> $fell(flashCeN) && !flashDqOe)
      else $error("read without fresh select");
   rd_pulse_a: assert property (!$past(regRdStb) |-> regRdData == 32'h0000_0000)
      else $error("read data outside its cycle");
   cover property ($fell(flashWeN));
   cover property ($fell(flashOeN));
   cover property (regRdStb ##1 regRdData != 32'h0000_0000);
endmodule // flash_host_props
bind flash_host flash_host_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (
   .clk_sys(clk_sys), .arst_n(arst_n), .regRdStb(regRdStb),
   .regRdData(regRdData), .flashAddr(flashAddr), .flashDqOut(flashDqOut),
   .flashDqOe(flashDqOe), .flashCeN(flashCeN), .flashOeN(flashOeN),
   .flashWeN(flashWeN));

// file: dv/flash_model.sv
// Behavioural flash device: commands, status byte, identifiers, array.
// Assumes the bench sets the fault inputs before each operation.
`timescale 1ns/1ps
module flash_model #(
   parameter logic [15:0] MAKER  = 16'h00A5, // Arbitrary value
   parameter logic [15:0] DEVICE = 16'h005B, // Arbitrary value
   parameter int          OP_NS  = 900
) (
   input  wire logic [17:0] addr,
   input  wire logic [15:0] dq,
   input  wire logic        ceN,
   input  wire logic        oeN,
   input  wire logic        weN,
   input  wire logic        vppLow,
   input  wire logic        progBad,
   input  wire logic        eraseBad,
   output logic      [15:0] dqIn
);
   logic [7:0]  sr = 8'h80;
   logic [7:0]  prev = 8'hFF;
   logic [7:0]  c;
   logic [1:0]  mode = 2'd0;
   logic [1:0]  pend = 2'd0;
   logic [15:0] lat = 16'h0000;
   realtime     doneAt = 0;
   realtime     rem = 0;
   always @(posedge weN) if (!ceN) begin
      c = dq[7:0];
      if (prev == 8'h40 || prev == 8'h10) begin
         mode = 2'd2;
         if (vppLow) sr[3] = 1'b1;
         else begin sr[7] = 1'b0; pend = 2'd1; doneAt = $realtime + OP_NS; end
      end else if (prev == 8'h20) begin
         mode = 2'd2;
         if (c != 8'hD0) sr = sr | 8'h30;
         else if (vppLow) sr = sr | 8'h28;
         else begin sr[7] = 1'b0; pend = 2'd2; doneAt = $realtime + OP_NS; end
      end else case (c)
         8'hFF: mode = 2'd0;
         8'h90: mode = 2'd1;
         8'h70: mode = 2'd2;
         8'h50: sr = sr & 8'hC7;
         8'hB0: if (pend == 2'd2 && !sr[7]) begin
            sr = sr | 8'hC0;
            rem = doneAt - $realtime;
         end
         8'hD0: if (sr[6]) begin sr[7:6] = 2'b00; doneAt = $realtime + rem; end
         default: ;
      endcase
      prev = (prev inside {8'h40, 8'h10, 8'h20}) ? 8'hFF : c;
   end
   always @(negedge ceN or negedge oeN) if (!ceN && !oeN) begin
      if (pend != 2'd0 && !sr[6] && $realtime >= doneAt) begin
         sr[7] = 1'b1;
         if (pend == 2'd1 && progBad) sr[4] = 1'b1;
         if (pend == 2'd2 && eraseBad) sr[5] = 1'b1;
         pend = 2'd0;
      end
      if (mode == 2'd2) lat = {8'h00, sr & 8'hF8};
      else if (mode == 2'd1) lat = addr[0] ? DEVICE : MAKER;
      else lat = ~addr[15:0];
   end
   assign dqIn = (!ceN && !oeN) ? lat : ~lat;
endmodule // flash_model

// file: dv/tb_flash_host.sv
// Self-checking bench for the flash host with a behavioural flash.
// Assumes flash_host_pkg and the flash model are compiled first.
`timescale 1ns/1ps
module tb_flash_host;
   logic        clk_sys = 1'b0;
   logic        arst_n = 1'b0;
   logic [7:0]  regAddr = 8'h00;
   logic [31:0] regWrData = 32'h0000_0000;
   logic        regWrStb = 1'b0;
   logic        regRdStb = 1'b0;
   logic [31:0] regRdData;
   logic [17:0] flashAddr;
   logic [15:0] flashDqOut, modelDq, dqBus;
   logic        flashDqOe, flashCeN, flashOeN, flashWeN;
   logic        vppLow = 1'b0, progBad = 1'b0, eraseBad = 1'b0;
   logic        clkEn = 1'b1;
   int          bad_count = 0, tests_run = 0;
   logic [31:0] s;
   assign dqBus = flashDqOe ? flashDqOut : modelDq;
   always #50 clk_sys = ~clk_sys;
   flash_host DUT (.clk_sys(clk_sys), .arst_n(arst_n), .clkEn(clkEn),
      .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
      .regRdStb(regRdStb), .regRdData(regRdData), .flashAddr(flashAddr),
      .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashDqIn(dqBus),
      .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN));
   flash_model u_flash (.addr(flashAddr), .dq(dqBus), .ceN(flashCeN),
      .oeN(flashOeN), .weN(flashWeN), .vppLow(vppLow), .progBad(progBad),
      .eraseBad(eraseBad), .dqIn(modelDq));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      regAddr <= a; regWrData <= d; regWrStb <= 1'b1;
      @(posedge clk_sys) regWrStb <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      regAddr <= a; regRdStb <= 1'b1;
      @(posedge clk_sys) regRdStb <= 1'b0;
      @(negedge clk_sys) d = regRdData;
      @(posedge clk_sys);
   endtask
   task automatic op(input logic [4:0] c, input logic [17:0] a, input logic [15:0] d);
      int n;
      n = 0;
      wr(flash_host_pkg::REG_ADDR, {14'h0000, a});
      wr(flash_host_pkg::REG_WDATA, {16'h0000, d});
      wr(flash_host_pkg::REG_CMD, {27'h000_0000, c});
      do begin rd(flash_host_pkg::REG_STATUS, s); n++; end
      while (s[0] !== 1'b0 && n < 500);
      chk({31'h0000_0000, s[0]}, 32'h0000_0000);
   endtask
   task automatic st(input logic [7:0] e);
      rd(flash_host_pkg::REG_STATUS, s);
      chk({s[15:8], 23'h00_0000, s[2]}, {e, 23'h00_0000, |e[5:3]});
   endtask
   task automatic dat(input logic [15:0] e);
      rd(flash_host_pkg::REG_RDATA, s);
      chk(s, {16'h0000, e});
   endtask
   task automatic t_reset;
      rd(flash_host_pkg::REG_STATUS, s); chk(s, 32'h0000_0000);
      wr(flash_host_pkg::REG_RDATA, 32'hFFFF_FFFF);
      dat(16'h0000);
      rd(8'h20, s); chk(s, 32'h0000_0000);
      // A write taken while the clock enable is low must be lost
      clkEn <= 1'b0;
      wr(flash_host_pkg::REG_ADDR, 32'h0000_0155);
      clkEn <= 1'b1;
      rd(flash_host_pkg::REG_ADDR, s); chk(s, 32'h0000_0000);
   endtask
   task automatic t_reads;
      op(5'h01, 18'h3_FFFE, 16'h0000); dat(16'h00A5);
      op(5'h01, 18'h0_0001, 16'h0000); dat(16'h005B);
      op(5'h00, 18'h0_1234, 16'h0000); dat(16'hEDCB);
   endtask
   task automatic t_program;
      progBad = 1'b1;
      op(5'h04, 18'h0_0100, 16'hA55A); st(8'h90);
      progBad = 1'b0;
      op(5'h14, 18'h0_0102, 16'h1234); st(8'h90);
      op(5'h03, 18'h0_0000, 16'h0000);
      op(5'h02, 18'h2_AAAA, 16'h0000); dat(16'h0080);
   endtask
   task automatic t_erase;
      eraseBad = 1'b1;
      op(5'h05, 18'h1_0000, 16'h0000); st(8'hA0);
      op(5'h03, 18'h0_0000, 16'h0000);
      eraseBad = 1'b0; vppLow = 1'b1;
      op(5'h05, 18'h1_0000, 16'h0000); st(8'hA8);
      vppLow = 1'b0;
      op(5'h03, 18'h0_0000, 16'h0000);
      op(5'h06, 18'h0_0000, 16'h0000); op(5'h07, 18'h0_0000, 16'h0000);
      op(5'h02, 18'h0_0000, 16'h0000); st(8'h80);
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #3_000_000;
      bad_count++;
      stop_test;
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      t_reset;
      t_reads;
      t_program;
      t_erase;
      stop_test;
   end
endmodule // tb_flash_host
